// File: iiob_pkg.sv
// Package for the isolated I/O byte port block: offsets, widths, access carrier
`default_nettype none
package iiob_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CHAN_N = 16;
  localparam int unsigned OFS_W = 2;
  localparam logic [1:0] OFS_IN_LO = 2'h0;
  localparam logic [1:0] OFS_IN_HI = 2'h1;
  localparam logic [1:0] OFS_OUT_LO = 2'h2;
  localparam logic [1:0] OFS_OUT_HI = 2'h3;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [15:0] BASE_RESET = 16'h0000;

  // One host byte cycle as seen by the block
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } iiob_req_t;
endpackage : iiob_pkg
`default_nettype wire

// File: iiob_out_latch.sv
// Output byte latch holding eight isolated output channels
`timescale 1ns/1ns
`default_nettype none
module iiob_out_latch #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Load strobe and data
  input wire logic load,
  input wire logic [W-1:0] din,
  // Latched drive states
  output logic [W-1:0] q
);
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    q_next = q_reg;
    if (load) begin
      q_next = din; // R7
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_reg <= W'(iiob_pkg::OUT_RESET);
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

  a_latch_holds: assert property (@(posedge clk) disable iff (!rst_n) // R7
    !load |=> q == $past(q))
    else $error("latch changed without a write");
endmodule : iiob_out_latch
`default_nettype wire

// File: iiob_ports.sv
// Isolated I/O byte ports: two input bytes and two output byte latches
// Contract
// R1: Host uses single-byte accesses only; wider accesses are not supported.
// R2: Ports decode relative to a base address set during configuration; code uses the aligned 4-byte block holding the base, offsets wrapping in it.
// R3: Read at offset 0 returns input channels 0 to 7.
// R4: Read at offset 1 returns input channels 8 to 15.
// R5: Write at offset 2 sets output channels 0 to 7; write-only.
// R6: Write at offset 3 sets output channels 8 to 15; write-only.
// R7: Output bytes are latched and hold until next write; bit n drives channel n.
`timescale 1ns/1ns
`default_nettype none
module iiob_ports #(
  parameter int unsigned ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Base address from configuration
  input wire logic base_load,
  input wire logic [ADDR_W-1:0] base_addr,
  // Host byte cycle
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_ack,
  output logic host_hit,
  // Field lines
  input wire logic [15:0] isolated_input_lines,
  output logic [15:0] isolated_output_lines
);
  logic [ADDR_W-1:0] base_reg;
  logic [ADDR_W-1:0] base_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic hit_reg;
  logic hit_next;
  logic in_win;
  logic [1:0] ofs;
  logic load_lo;
  logic load_hi;
  logic [7:0] out_lo;
  logic [7:0] out_hi;
  logic [15:0] out_reg;
  iiob_pkg::iiob_req_t req;

  // Window check against the assigned base; lower two bits select the port
  function automatic logic win_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    win_hit = (a[ADDR_W-1:2] == b[ADDR_W-1:2]);
  endfunction : win_hit

  // Carrier keeps the qualifiers of one byte cycle together
  always_comb begin
    req.rd = host_rd;
    req.wr = host_wr;
    req.addr = 16'(host_addr);
    req.wdata = host_wdata;
  end

  assign in_win = win_hit(host_addr, base_reg); // R2
  assign ofs = host_addr[1:0] - base_reg[1:0]; // R2
  assign load_lo = req.wr && in_win && ofs == iiob_pkg::OFS_OUT_LO; // R5
  assign load_hi = req.wr && in_win && ofs == iiob_pkg::OFS_OUT_HI; // R6

  always_comb begin
    base_next = base_reg;
    if (base_load) begin
      base_next = base_addr; // R2
    end
  end

  // Only byte cycles exist on this port, so wider accesses cannot occur
  always_comb begin
    rdata_next = rdata_reg;
    ack_next = req.rd || req.wr; // R1
    hit_next = (req.rd || req.wr) && in_win; // R2
    if (req.rd) begin
      rdata_next = iiob_pkg::RD_UNMAPPED;
      if (in_win) begin
        case (ofs)
          iiob_pkg::OFS_IN_LO: rdata_next = isolated_input_lines[7:0]; // R3
          iiob_pkg::OFS_IN_HI: rdata_next = isolated_input_lines[15:8]; // R4
          // Output ports are write-only and read as zero
          default: rdata_next = iiob_pkg::RD_UNMAPPED; // R5 R6
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_reg <= ADDR_W'(iiob_pkg::BASE_RESET);
      rdata_reg <= iiob_pkg::RD_UNMAPPED;
      ack_reg <= 1'b0;
      hit_reg <= 1'b0;
      out_reg <= {iiob_pkg::OUT_RESET, iiob_pkg::OUT_RESET};
    end else begin
      base_reg <= base_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      hit_reg <= hit_next;
      out_reg <= {out_hi, out_lo};
    end
  end

  iiob_out_latch #(.W(iiob_pkg::DATA_W)) u_lo (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_lo),
    .din(req.wdata),
    .q(out_lo)
  );

  iiob_out_latch #(.W(iiob_pkg::DATA_W)) u_hi (
    .clk(clk),
    .rst_n(rst_n),
    .load(load_hi),
    .din(req.wdata),
    .q(out_hi)
  );

  // Extra flop keeps outputs registered; costs one cycle of latency to the field
  assign host_rdata = rdata_reg;
  assign host_ack = ack_reg;
  assign host_hit = hit_reg;
  assign isolated_output_lines = out_reg; // R7

  // Read path
  a_read_low: assert property (@(posedge clk) disable iff (!rst_n) // R3
    host_rd && in_win && ofs == iiob_pkg::OFS_IN_LO
    |=> host_rdata == $past(isolated_input_lines[7:0]))
    else $error("low input byte read wrong");
  a_read_high: assert property (@(posedge clk) disable iff (!rst_n) // R4
    host_rd && in_win && ofs == iiob_pkg::OFS_IN_HI
    |=> host_rdata == $past(isolated_input_lines[15:8]))
    else $error("high input byte read wrong");
  a_out_ro_read: assert property (@(posedge clk) disable iff (!rst_n) // R5 R6
    host_rd && ofs[1]
    |=> host_rdata == 8'h00)
    else $error("write-only port read nonzero");
  a_miss_read: assert property (@(posedge clk) disable iff (!rst_n) // R2
    host_rd && !in_win
    |=> host_rdata == 8'h00)
    else $error("read outside window returned data");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n) // R3
    !host_rd
    |=> $stable(host_rdata))
    else $error("read data changed without a read");

  // Write path
  a_write_low: assert property (@(posedge clk) disable iff (!rst_n) // R5
    load_lo
    |=> ##1 isolated_output_lines[7:0] == $past(host_wdata, 2))
    else $error("low output byte not written");
  a_write_high: assert property (@(posedge clk) disable iff (!rst_n) // R6
    load_hi
    |=> ##1 isolated_output_lines[15:8] == $past(host_wdata, 2))
    else $error("high output byte not written");
  a_ro_write: assert property (@(posedge clk) disable iff (!rst_n) // R3
    host_wr && in_win && !ofs[1]
    |=> ##1 isolated_output_lines == $past(isolated_output_lines))
    else $error("write to input port changed outputs");
  a_miss_ignored: assert property (@(posedge clk) disable iff (!rst_n) // R2
    host_wr && !in_win
    |=> ##1 isolated_output_lines == $past(isolated_output_lines))
    else $error("write outside window changed outputs");
  a_out_hold: assert property (@(posedge clk) disable iff (!rst_n) // R7
    !host_wr [*3]
    |-> isolated_output_lines == $past(isolated_output_lines))
    else $error("outputs drifted without write");
  a_low_hold: assert property (@(posedge clk) disable iff (!rst_n) // R7
    !load_lo
    |=> ##1 isolated_output_lines[7:0] == $past(isolated_output_lines[7:0]))
    else $error("low output byte changed without its write");
  a_high_hold: assert property (@(posedge clk) disable iff (!rst_n) // R7
    !load_hi
    |=> ##1 isolated_output_lines[15:8] == $past(isolated_output_lines[15:8]))
    else $error("high output byte changed without its write");

  // Acknowledge and decode
  a_ack_single: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (host_rd || host_wr)
    |=> host_ack)
    else $error("byte cycle not acknowledged");
  a_ack_idle: assert property (@(posedge clk) disable iff (!rst_n) // R1
    !(host_rd || host_wr)
    |=> !host_ack && !host_hit)
    else $error("acknowledge without a byte cycle");
  a_hit_window: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (host_rd || host_wr) && in_win
    |=> host_hit)
    else $error("window access not flagged as hit");
  a_miss_no_hit: assert property (@(posedge clk) disable iff (!rst_n) // R2
    (host_rd || host_wr) && !in_win
    |=> !host_hit)
    else $error("access outside window flagged as hit");
  a_hit_with_ack: assert property (@(posedge clk) disable iff (!rst_n) // R2
    host_hit
    |-> host_ack)
    else $error("hit without acknowledge");
  a_base_load: assert property (@(posedge clk) disable iff (!rst_n) // R2
    base_load
    |=> base_reg == $past(base_addr))
    else $error("base address not taken");
  a_base_hold: assert property (@(posedge clk) disable iff (!rst_n) // R2
    !base_load
    |=> $stable(base_reg))
    else $error("base address changed without a load");

  // Reset drives the field lines to zero and leaves the bus quiet
  a_reset_clear: assert property (@(posedge clk) // R7
    !rst_n
    |=> !host_ack && !host_hit && host_rdata == 8'h00 && isolated_output_lines == 16'h0000)
    else $error("reset did not clear outputs");

  c_read_low: cover property (@(posedge clk) host_rd && in_win && ofs == 2'h0);
  c_read_high: cover property (@(posedge clk) host_rd && in_win && ofs == 2'h1);
  c_write_both: cover property (@(posedge clk) load_lo ##1 load_hi);
  c_rebase: cover property (@(posedge clk) base_load ##1 host_wr && in_win);
  c_miss_write: cover property (@(posedge clk) host_wr && !in_win);
endmodule : iiob_ports
`default_nettype wire

// File: iiob_host_model.sv
// Host master model issuing single byte I/O cycles
`timescale 1ns/1ns
`default_nettype none
module iiob_host_model (
  // Clock
  input wire logic clk,
  // Byte request
  output logic rd,
  output logic wr,
  output logic [15:0] addr,
  output logic [7:0] wdata
);
  initial begin
    rd = 1'h0;
    wr = 1'h0;
    addr = 16'h0000;
    wdata = 8'h00;
  end
  // Released strobes drop; address and data invert so a stale value never matches
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    rd = ~w;
    wr = w;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    rd = 1'h0;
    wr = 1'h0;
    addr = ~a;
    wdata = ~d;
  endtask : xfer
endmodule : iiob_host_model
`default_nettype wire

// File: isolated_io_byte_ports_tb.sv
// Self-checking bench for the isolated I/O byte ports
`timescale 1ns/1ns
`default_nettype none
module isolated_io_byte_ports_tb;
  logic clk, rst_n, base_load, rd, wr, ack, hit;
  logic [15:0] base_addr, addr, in_lines, out_lines;
  logic [7:0] wdata, rdata;
  int mismatches = 0, comparisons = 0, cycles = 0;
  iiob_ports uut (.clk(clk), .rst_n(rst_n), .base_load(base_load), .base_addr(base_addr),
    .host_rd(rd), .host_wr(wr), .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata),
    .host_ack(ack), .host_hit(hit), .isolated_input_lines(in_lines),
    .isolated_output_lines(out_lines));
  iiob_host_model host (.clk(clk), .rd(rd), .wr(wr), .addr(addr), .wdata(wdata));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e,
    input logic hi);
    host.xfer(1'h0, a, 8'h00);
    check(n, {6'h00, rdata, ack, hit}, {6'h00, e, 1'h1, hi});
  endtask : rd_chk
  // Outputs settle one cycle after the answer
  task automatic wr_chk(input string n, input logic [15:0] a, input logic [7:0] d,
    input logic hi, input logic [15:0] e);
    host.xfer(1'h1, a, d);
    check(n, {14'h0000, ack, hit}, {14'h0000, 1'h1, hi});
    @(posedge clk);
    #1;
    check(n, out_lines, e);
  endtask : wr_chk
  // Inputs are read live; write-only places and misses read zero
  task automatic reads(input logic [15:0] b);
    in_lines = 16'hA55A;
    rd_chk("in_lo", b, 8'h5A, 1'h1);
    rd_chk("in_hi", b + 16'h0001, 8'hA5, 1'h1);
    in_lines = 16'h3CC3;
    rd_chk("in_lo_new", b, 8'hC3, 1'h1);
    rd_chk("out_lo_rd", b + 16'h0002, 8'h00, 1'h1);
    rd_chk("out_hi_rd", b + 16'h0003, 8'h00, 1'h1);
    rd_chk("miss_rd", b + 16'h0004, 8'h00, 1'h0);
  endtask : reads
  // Complementary high and low bytes expose a swapped byte; a miss leaves the latches alone
  task automatic writes(input logic [15:0] b, input logic [7:0] hi0);
    wr_chk("out_lo", b + 16'h0002, 8'h81, 1'h1, {hi0, 8'h81});
    wr_chk("out_hi", b + 16'h0003, 8'h7E, 1'h1, 16'h7E81);
    wr_chk("miss_wr", b + 16'h0006, 8'hFF, 1'h0, 16'h7E81);
    wr_chk("out_lo2", b + 16'h0002, 8'h10, 1'h1, 16'h7E10);
    wr_chk("in_lo_wr", b, 8'hFF, 1'h1, 16'h7E10);
    wr_chk("in_hi_wr", b + 16'h0001, 8'h00, 1'h1, 16'h7E10);
  endtask : writes
  initial begin
    rst_n = 1'h0;
    base_load = 1'h1;
    base_addr = 16'h0300;
    in_lines = 16'h0000;
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'h1;
    check("out_reset", out_lines, 16'h0000);
    check("bus_reset", {6'h00, rdata, ack, hit}, 16'h0000);
    reads(16'h0300);
    writes(16'h0300, 8'h00);
    base_addr = 16'hFFFC;
    reads(16'hFFFC);
    base_load = 1'h0;
    base_addr = 16'h0000;
    writes(16'hFFFC, 8'h7E);
    final_report();
  end
endmodule : isolated_io_byte_ports_tb
`default_nettype wire
